// >>> src/hbc_pkg.sv
// Summary of operation
// [RULE1] Enable low floats that phase output.
// [RULE2] Enable high, command low drives output low.
// [RULE3] Enable high, command high drives output high.
// [RULE4] Each phase decodes command/enable independently.
// [RULE5] Both flags are active-low open-drain.
// [RULE6] Any shutdown pulls the shutdown flag low.
// [RULE7] Warning flag low above 125 C.
// [RULE8] Decode flag pair into four status cases.
// [RULE9] Fault floats outputs, pulls shutdown flag low.
// [RULE10] Non-latched faults recover by themselves.
// [RULE11] Wait one second before external reset.
// [RULE12] Short floats transistors within 250 ns.
// [RULE13] Low bootstrap inserts high-side recharge gaps.
// [RULE14] Too-high duty may start bootstrap recharge.
// [RULE15] Keep low side on 50 ns each cycle.
// [RULE16] Reduce load current while warning is low.
// [RULE17] Enable rising edge clears a phase fault.
// [RULE18] Latched faults clear by cycling all enables.
// [RULE19] Two overcurrent modes chosen by mode pins.
// [RULE20] Per-cycle limit holds bridge off one cycle.
// [RULE21] Mode pins static, changed only while disabled.
package hbc_pkg;
    // clock
    localparam int HBC_CLK_PERIOD_NS = 4;
    localparam int HBC_CLK_HZ        = 250_000_000;
    // least low-side on time per pwm cycle, rounded up
    localparam int HBC_MIN_LOW_NS     = 50;
    localparam int HBC_MIN_LOW_CYCLES =
        (HBC_MIN_LOW_NS + HBC_CLK_PERIOD_NS - 1) / HBC_CLK_PERIOD_NS;
    // hold-off after a shutdown before an external reset
    localparam int HBC_HOLDOFF_S      = 1;
    localparam int HBC_HOLDOFF_CYCLES = HBC_HOLDOFF_S * HBC_CLK_HZ;
    // time all enables stay low during a reset pulse, rounded up
    localparam int HBC_ENABLE_LOW_NS     = 100;
    localparam int HBC_ENABLE_LOW_CYCLES =
        (HBC_ENABLE_LOW_NS + HBC_CLK_PERIOD_NS - 1) / HBC_CLK_PERIOD_NS;
    // widths
    localparam int HBC_PWM_W   = 16;
    localparam int HBC_HOLD_W  = 28;
    localparam int HBC_LOW_W   = 8;
    localparam int HBC_PHASES  = 3;
    localparam int HBC_MODE_W  = 3;
    // reset values
    localparam logic [HBC_MODE_W-1:0] HBC_MODE_RESET = 3'h0;
    // decoded flag pair
    typedef enum logic [1:0] {
        HBC_FLAG_NORMAL   = 2'h0,  // both flags high
        HBC_FLAG_WARNING  = 2'h1,  // warning only
        HBC_FLAG_SHUTDOWN = 2'h2,  // shutdown only: thermal, overcurrent or gate supply
        HBC_FLAG_BOTH     = 2'h3   // warning plus shutdown
    } hbc_flag_t;
    // controller states, one-hot
    typedef enum logic [3:0] {
        HBC_ST_IDLE      = 4'h1,   // all enables low, mode pins may change
        HBC_ST_RUN       = 4'h2,   // phases enabled, pwm running
        HBC_ST_HOLDOFF   = 4'h4,   // shutdown seen, waiting
        HBC_ST_RESET_LOW = 4'h8    // all enables low for the reset pulse
    } hbc_state_t;
endpackage : hbc_pkg

// >>> src/hbc_phase_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_phase_pwm
    import hbc_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [HBC_PWM_W-1:0] pwmCount,  // shared period counter
    input  wire logic [HBC_PWM_W-1:0] pwmPeriod, // last count of a cycle
    input  wire logic [HBC_PWM_W-1:0] duty,      // requested high cycles
    input  wire logic                 derate,    // halve duty on warning
    output logic                      command    // high: high side on
);
    logic [HBC_PWM_W:0]   lowLimit;     // largest duty that keeps low time
    logic [HBC_PWM_W:0]   effDuty;      // duty after derate and clamp
    logic                 next_command;

    ////////////////////////////////////////////////////////////////////////
    // duty shaping: derate first, then clamp the off time
    always_comb begin
        effDuty = derate ? {2'h0, duty[HBC_PWM_W-1:1]} : {1'h0, duty}; // RULE16
        // cycle length is pwmPeriod+1; reserve the least low time for recharge
        if ({1'h0, pwmPeriod} + 17'h1 > 17'(HBC_MIN_LOW_CYCLES)) begin
            lowLimit = {1'h0, pwmPeriod} + 17'h1 - 17'(HBC_MIN_LOW_CYCLES);
        end else begin
            lowLimit = 17'h0;
        end
        if (effDuty > lowLimit) begin
            effDuty = lowLimit;                                       // RULE15
        end
        next_command = ({1'h0, pwmCount} < effDuty);
    end

    // command is a data output, so it leaves from a flop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            command <= 1'b0;
        end else begin
            command <= next_command;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the last counts of every cycle always command the low side
    a_low_tail_min: assert property (@(posedge sys_clk) disable iff (reset) // RULE15
        ({1'h0, $past(pwmCount)} + 17'(HBC_MIN_LOW_CYCLES) > {1'h0, $past(pwmPeriod)})
        && $past(pwmPeriod) == pwmPeriod && !$past(reset) |-> !command)
        else $error("low side on time below minimum");
endmodule : hbc_phase_pwm
`default_nettype wire

// >>> src/hbc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_controller
    import hbc_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = HBC_HOLDOFF_CYCLES // shorten in sim
)(
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // user side
    input  wire logic                  runRequest,    // level: run the bridge
    input  wire logic                  clearRequest,  // pulse: clear latched fault
    input  wire logic [HBC_MODE_W-1:0] modeRequest,   // wanted mode pin levels
    input  wire logic [HBC_PWM_W-1:0]  pwmPeriod,     // last count of a cycle
    input  wire logic [HBC_PWM_W-1:0]  dutyA,
    input  wire logic [HBC_PWM_W-1:0]  dutyB,
    input  wire logic [HBC_PWM_W-1:0]  dutyC,
    output hbc_flag_t                  flagStatus,    // decoded flag pair
    output logic                       loadReduced,   // duty halved on warning
    output logic                       holdoffDone,   // reset now permitted
    output logic                       running,       // phases enabled
    // device side
    output logic [HBC_PHASES-1:0]      phaseCommand,  // per-phase command pins
    output logic [HBC_PHASES-1:0]      phaseEnable,   // per-phase enable pins
    output logic                       mode_select_0,
    output logic                       mode_select_1,
    output logic                       mode_select_2,
    input  wire logic                  shutdown_n,        // open-drain flag
    input  wire logic                  thermal_warning_n  // open-drain flag
);
    ////////////////////////////////////////////////////////////////////////
    // flag synchronisers: the pins are asynchronous to sys_clk
    logic [1:0] shutdownSync;      // [0] first stage, read only by [1]
    logic [1:0] warningSync;
    logic       shutdownLow;       // second stage, usable level
    logic       warningLow;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shutdownSync <= 2'h3;  // released flags read high
            warningSync  <= 2'h3;
        end else begin
            shutdownSync <= {shutdownSync[0], shutdown_n};
            warningSync  <= {warningSync[0], thermal_warning_n};
        end
    end
    assign shutdownLow = !shutdownSync[1];  // RULE5
    assign warningLow  = !warningSync[1];

    // decoding of the flag pair, used for status and for the derate decision
    function automatic hbc_flag_t decode_flags(input logic sdLow, input logic owLow);
        if (sdLow && owLow) begin
            decode_flags = HBC_FLAG_BOTH;
        end else if (sdLow) begin
            decode_flags = HBC_FLAG_SHUTDOWN;
        end else if (owLow) begin
            decode_flags = HBC_FLAG_WARNING;
        end else begin
            decode_flags = HBC_FLAG_NORMAL;
        end
    endfunction : decode_flags

    ////////////////////////////////////////////////////////////////////////
    // status registers
    hbc_flag_t next_flagStatus;
    logic      next_loadReduced;

    always_comb begin
        next_flagStatus  = decode_flags(shutdownLow, warningLow);       // RULE8
        // warning in either case asks for less current
        next_loadReduced = (next_flagStatus == HBC_FLAG_WARNING)        // RULE16
                        || (next_flagStatus == HBC_FLAG_BOTH);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flagStatus  <= HBC_FLAG_NORMAL;
            loadReduced <= 1'b0;
        end else begin
            flagStatus  <= next_flagStatus;
            loadReduced <= next_loadReduced;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing state machine
    hbc_state_t                  state, next_state;
    logic [HBC_HOLD_W-1:0]       holdCount, next_holdCount;   // since shutdown
    logic [HBC_LOW_W-1:0]        lowCount, next_lowCount;     // reset pulse
    logic                        clearPending, next_clearPending;
    logic [HBC_MODE_W-1:0]       modePins, next_modePins;
    logic                        holdReached;

    assign holdReached = (32'(holdCount) >= HOLDOFF_CYCLES - 1);

    always_comb begin
        next_state        = state;
        next_holdCount    = holdCount;
        next_lowCount     = lowCount;
        next_modePins     = modePins;
        // a request in the clearing cycle is kept, except in HBC_ST_IDLE: set wins
        next_clearPending = clearPending || clearRequest;
        unique case (state)
            HBC_ST_IDLE: begin
                // mode pins only move while every phase is disabled
                next_clearPending = 1'b0;
                // the pins freeze on the leaving edge, so they never move
                // in the same clock as the enables rise
                if (runRequest) begin
                    next_state = HBC_ST_RUN;
                end else begin
                    next_modePins = modeRequest;                        // RULE21
                end
            end
            HBC_ST_RUN: begin
                next_clearPending = clearRequest;
                if (!runRequest) begin
                    next_state = HBC_ST_IDLE;
                end else if (shutdownLow) begin                          // RULE9
                    next_state     = HBC_ST_HOLDOFF;
                    next_holdCount = '0;
                end
            end
            HBC_ST_HOLDOFF: begin
                if (!holdReached) begin
                    next_holdCount = holdCount + 1'b1;                  // RULE11
                end
                if (!runRequest) begin
                    next_state = HBC_ST_IDLE;
                end else if (!shutdownLow) begin
                    // undervoltage and similar faults release by themselves
                    next_state = HBC_ST_RUN;                            // RULE10
                end else if (holdReached && clearPending) begin
                    next_state        = HBC_ST_RESET_LOW;               // RULE11
                    next_lowCount     = '0;
                    // a request in the consuming cycle is kept: set wins
                    next_clearPending = clearRequest;
                end
            end
            HBC_ST_RESET_LOW: begin
                // all three enables low, then high together if runRequest holds, else left low in HBC_ST_IDLE
                next_lowCount = lowCount + 1'b1;                        // RULE18
                if (32'(lowCount) == HBC_ENABLE_LOW_CYCLES - 1) begin
                    next_state = runRequest ? HBC_ST_RUN : HBC_ST_IDLE; // RULE17
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state        <= HBC_ST_IDLE;
            holdCount    <= '0;
            lowCount     <= '0;
            clearPending <= 1'b0;
            modePins     <= HBC_MODE_RESET;
        end else begin
            state        <= next_state;
            holdCount    <= next_holdCount;
            lowCount     <= next_lowCount;
            clearPending <= next_clearPending;
            modePins     <= next_modePins;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable pins and run status from flops; enables share one value, so a
    // latched fault always sees all three phases cycle together
    logic next_enable;
    logic next_holdoffDone;

    always_comb begin
        next_enable      = (next_state == HBC_ST_RUN) || (next_state == HBC_ST_HOLDOFF);
        next_holdoffDone = (next_state == HBC_ST_HOLDOFF) && holdReached;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phaseEnable <= '0;                                          // RULE1
            running     <= 1'b0;
            holdoffDone <= 1'b0;
        end else begin
            phaseEnable <= {HBC_PHASES{next_enable}};                   // RULE18
            running     <= next_enable;
            holdoffDone <= next_holdoffDone;
        end
    end

    assign mode_select_0 = modePins[0];
    assign mode_select_1 = modePins[1];
    assign mode_select_2 = modePins[2];

    ////////////////////////////////////////////////////////////////////////
    // shared period counter; wraps at pwmPeriod
    logic [HBC_PWM_W-1:0] pwmCount, next_pwmCount;

    always_comb begin
        next_pwmCount = (pwmCount >= pwmPeriod) ? '0 : pwmCount + 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwmCount <= '0;
        end else begin
            pwmCount <= next_pwmCount;
        end
    end

    // one command generator per phase, each with its own duty
    logic [HBC_PWM_W-1:0] dutyArr [HBC_PHASES];
    assign dutyArr[0] = dutyA;
    assign dutyArr[1] = dutyB;
    assign dutyArr[2] = dutyC;

    for (genvar p = 0; p < HBC_PHASES; p++) begin : g_phase            // RULE4
        hbc_phase_pwm u_pwm (
            .sys_clk   (sys_clk),
            .reset     (reset),
            .pwmCount  (pwmCount),
            .pwmPeriod (pwmPeriod),
            .duty      (dutyArr[p]),
            .derate    (loadReduced),
            .command   (phaseCommand[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_mode_static: assert property (@(posedge sys_clk) disable iff (reset) // RULE21
        $changed(modePins) |-> $past(phaseEnable) == '0 && phaseEnable == '0)
        else $error("mode pins changed while a phase was enabled");
    a_enables_aligned: assert property (@(posedge sys_clk) disable iff (reset) // RULE18
        phaseEnable == '0 || phaseEnable == {HBC_PHASES{1'b1}})
        else $error("phase enables differ");
    a_flag_decode: assert property (@(posedge sys_clk) disable iff (reset) // RULE8
        shutdownLow && !warningLow |=> flagStatus == HBC_FLAG_SHUTDOWN)
        else $error("shutdown only case decoded wrong");
    a_warn_derate: assert property (@(posedge sys_clk) disable iff (reset) // RULE16
        warningLow |=> loadReduced)
        else $error("load not reduced under warning");
    a_holdoff_min: assert property (@(posedge sys_clk) disable iff (reset) // RULE11
        state == HBC_ST_HOLDOFF && next_state == HBC_ST_RESET_LOW
        |-> 32'(holdCount) >= HOLDOFF_CYCLES - 1)
        else $error("reset before hold-off elapsed");
    a_reset_pulse_low: assert property (@(posedge sys_clk) disable iff (reset) // RULE18
        $rose(state == HBC_ST_RESET_LOW) |=> (phaseEnable == '0) [*8])
        else $error("enables not held low in reset pulse");
    a_fault_entry: assert property (@(posedge sys_clk) disable iff (reset) // RULE9
        state == HBC_ST_RUN && runRequest && shutdownLow |=> state == HBC_ST_HOLDOFF)
        else $error("shutdown not followed by hold-off");
    a_auto_resume: assert property (@(posedge sys_clk) disable iff (reset) // RULE10
        state == HBC_ST_HOLDOFF && runRequest && !shutdownLow
        |=> state == HBC_ST_RUN && phaseEnable == {HBC_PHASES{1'b1}})
        else $error("no resume after self-clearing fault");

    c_reset_pulse: cover property (@(posedge sys_clk) $rose(state == HBC_ST_RESET_LOW));
    c_auto_resume: cover property (@(posedge sys_clk)
        state == HBC_ST_HOLDOFF ##1 state == HBC_ST_RUN);
    c_derated_run: cover property (@(posedge sys_clk) running && loadReduced);
endmodule : hbc_controller
`default_nettype wire

// >>> test/hbc_device_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// behavioural power stage: no clock, reacts to pin levels at once
module hbc_device_model (
    input  wire logic [2:0] phaseCommand, // high: high side wanted
    input  wire logic [2:0] phaseEnable,  // low: phase floats
    input  wire logic       hotWarn,      // junction above warning level
    input  wire logic       hotTrip,      // thermal shutdown event
    input  wire logic       overTrip,     // overcurrent event, latching
    input  wire logic       supplyLow,    // gate supply undervoltage
    input  wire logic       perCycle,     // mode pins pick per-cycle limiting
    input  wire logic [2:0] limitHit,     // per-phase current limit events
    input  wire logic       bootLow,      // bootstrap below safe level
    output logic      [2:0] highOn,       // high-side transistor on
    output logic      [2:0] lowOn,        // low-side transistor on
    output logic            faultPull,    // enable: pulls shutdown flag low
    output logic            warnPull      // enable: pulls warning flag low
);
    logic latched;   // thermal or overcurrent shutdown held
    logic sawAllLow; // every enable seen low since the trip
    logic shutdown;  // any shutdown cause present
    logic [2:0] prevCommand; // command seen at the last change
    logic [2:0] limitOff;    // phases blanked until their next pwm cycle
    logic [2:0] highMask;    // high sides allowed on
    initial begin
        latched = 1'b0;
        sawAllLow = 1'b0;
        prevCommand = 3'h0;
        limitOff = 3'h0;
    end
    // a limit hit blanks its phase; a rising command opens the next cycle
    always @(phaseCommand or limitHit or perCycle) begin
        limitOff = perCycle ? ((limitOff & ~(phaseCommand & ~prevCommand)) | limitHit) : 3'h0;
        prevCommand = phaseCommand;
    end
    // recharge gaps keep the high side off while the bootstrap is low
    assign highMask = ~limitOff & {3{!bootLow}};
    ////////////////////////////////////////////////////////////////////////////
    // a trip latches; only a full low-then-high cycle of all enables clears it
    always @(posedge hotTrip or posedge overTrip) begin
        latched = 1'b1;
        sawAllLow = 1'b0;
    end
    // one phase alone cannot clear it, so wait for all three
    always @(phaseEnable) begin
        if (phaseEnable == 3'h0) begin
            sawAllLow = 1'b1;
        end
        if (phaseEnable == 3'h7 && sawAllLow && !hotTrip && !overTrip) begin
            latched = 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // supply loss is not latched, so the stage resumes by itself
    assign shutdown  = latched | supplyLow;
    assign faultPull = shutdown;
    assign warnPull  = hotWarn;
    // zero-delay float keeps the trip response well inside its budget
    assign highOn = shutdown ? 3'h0 : (phaseEnable & phaseCommand & highMask);
    assign lowOn  = shutdown ? 3'h0 : (phaseEnable & ~phaseCommand & ~limitOff);
endmodule : hbc_device_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hbc_pkg::*;
    localparam int HOLD = 50;  // shortened hold-off
    localparam int PER  = 31;  // pwm cycle of 32 clocks
    logic        sys_clk, reset, runRequest, clearRequest;
    logic [2:0]  modeRequest;
    logic [15:0] dutyA, dutyB, dutyC;
    hbc_flag_t   flagStatus;
    logic        loadReduced, holdoffDone, running;
    logic [2:0]  phaseCommand, phaseEnable;
    logic        mode_select_0, mode_select_1, mode_select_2;
    logic        shutdown_n, thermal_warning_n, faultPull, warnPull;
    logic        hotWarn, hotTrip, overTrip, supplyLow;
    int          failures, checks_done;
    ////////////////////////////////////////////////////////////////////////////
    // clock and open-drain flags with pull-ups
    always #2 sys_clk = ~sys_clk;
    assign shutdown_n        = faultPull ? 1'b0 : 1'b1;
    assign thermal_warning_n = warnPull ? 1'b0 : 1'b1;
    hbc_controller #(.HOLDOFF_CYCLES(HOLD)) uut (
        .sys_clk(sys_clk), .reset(reset), .runRequest(runRequest),
        .clearRequest(clearRequest), .modeRequest(modeRequest),
        .pwmPeriod(16'(PER)), .dutyA(dutyA), .dutyB(dutyB), .dutyC(dutyC),
        .flagStatus(flagStatus), .loadReduced(loadReduced),
        .holdoffDone(holdoffDone), .running(running),
        .phaseCommand(phaseCommand), .phaseEnable(phaseEnable),
        .mode_select_0(mode_select_0), .mode_select_1(mode_select_1),
        .mode_select_2(mode_select_2), .shutdown_n(shutdown_n),
        .thermal_warning_n(thermal_warning_n));
    hbc_device_model dev (
        .phaseCommand(phaseCommand), .phaseEnable(phaseEnable), .hotWarn(hotWarn),
        .hotTrip(hotTrip), .overTrip(overTrip), .supplyLow(supplyLow),
        .perCycle(mode_select_0), .limitHit(3'h0), .bootLow(1'b0),
        .highOn(), .lowOn(), .faultPull(faultPull), .warnPull(warnPull));
    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic close_out;
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // high clocks of each command over one whole pwm cycle
    task automatic count_high(output int na, output int nb, output int nc);
        na = 0;
        nb = 0;
        nc = 0;
        repeat (PER + 1) begin
            @(negedge sys_clk);
            na += (phaseCommand[0] === 1'b1);
            nb += (phaseCommand[1] === 1'b1);
            nc += (phaseCommand[2] === 1'b1);
        end
    endtask : count_high
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset;
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        tick(1);
        check(16'(phaseEnable), 16'h0000);
        check(16'(flagStatus), 16'h0000);
        check(16'({mode_select_2, mode_select_1, mode_select_0}), 16'h0000);
    endtask : test_reset
    task automatic test_pwm;
        int na, nb, nc;
        runRequest = 1'b1;
        tick(4);
        check(16'(phaseEnable), 16'h0007);
        count_high(na, nb, nc);
        check(16'(na), 16'h0008);
        check(16'(nb), 16'h0013);
        check(16'(nc), 16'h0000);
    endtask : test_pwm
    task automatic test_warn;
        int na, nb, nc;
        hotWarn = 1'b1;
        tick(4);
        check(16'(flagStatus), 16'h0001);
        check(16'(loadReduced), 16'h0001);
        count_high(na, nb, nc);
        check(16'(na), 16'h0004);
        hotWarn = 1'b0;
        tick(4);
        check(16'(loadReduced), 16'h0000);
    endtask : test_warn
    task automatic test_selfclear;
        supplyLow = 1'b1;
        hotWarn = 1'b1;
        tick(4);
        check(16'(flagStatus), 16'h0003);
        hotWarn = 1'b0;
        tick(4);
        check(16'(flagStatus), 16'h0002);
        supplyLow = 1'b0;
        tick(6);
        check(16'(flagStatus), 16'h0000);
        check(16'(phaseEnable), 16'h0007);
        // a controller stuck in hold-off would report the wait as done
        tick(HOLD);
        check(16'(holdoffDone), 16'h0000);
    endtask : test_selfclear
    task automatic test_latched;
        int n;
        hotTrip = 1'b1;
        tick(1);
        hotTrip = 1'b0;
        tick(20);
        check(16'(flagStatus), 16'h0002);
        check(16'(holdoffDone), 16'h0000);
        n = 21;
        // two sync stages and the entry edge come before the hold-off count
        while (holdoffDone !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check(16'(n), 16'(HOLD + 3));
        // only now is the clear asked for
        clearRequest = 1'b1;
        for (int i = 0; i < 10 && phaseEnable !== 3'h0; i++) begin
            tick(1);
        end
        clearRequest = 1'b0;
        check(16'(phaseEnable), 16'h0000);
        n = 0;
        while (phaseEnable !== 3'h7 && n < 100) begin
            tick(1);
            n++;
        end
        check(16'(n), 16'h0019);
        tick(6);
        check(16'(flagStatus), 16'h0000);
        check(16'(running), 16'h0001);
    endtask : test_latched
    task automatic test_mode;
        runRequest = 1'b0;
        tick(4);
        check(16'(phaseEnable), 16'h0000);
        modeRequest = 3'h5;
        tick(3);
        check(16'({mode_select_2, mode_select_1, mode_select_0}), 16'h0005);
        runRequest = 1'b1;
        tick(3);
        modeRequest = 3'h2;
        tick(3);
        check(16'({mode_select_2, mode_select_1, mode_select_0}), 16'h0005);
    endtask : test_mode
    ////////////////////////////////////////////////////////////////////////////
    // main sequence; inputs change only at falling edges
    initial begin
        sys_clk = 1'b0;
        reset = 1'b1;
        runRequest = 1'b0;
        clearRequest = 1'b0;
        modeRequest = 3'h0;
        dutyA = 16'h0008;
        dutyB = 16'h0028;
        dutyC = 16'h0000;
        hotWarn = 1'b0;
        hotTrip = 1'b0;
        overTrip = 1'b0;
        supplyLow = 1'b0;
        failures = 0;
        checks_done = 0;
        test_reset();
        test_pwm();
        test_warn();
        test_selfclear();
        test_latched();
        test_mode();
        close_out();
    end
    // watchdog: the run needs well under a thousand clocks
    initial begin
        #(4 * 20000);
        failures++;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
